//--- hdl/trig_defs.vh
`ifndef TRIG_DEFS_VH
`define TRIG_DEFS_VH

// APB register byte offsets
`define REG_CTRL        12'h000
`define REG_GATE_DELAY  12'h004
`define REG_GATE_ON     12'h008
`define REG_GATE_PERIOD 12'h00C
`define REG_RETRY       12'h010
`define REG_STATUS      12'h014
`define REG_RESULT      12'h018

// Control register fields
`define CTRL_RUN_BIT    0
`define CTRL_MON_BIT    1
`define CTRL_LEVEL_BIT  2
`define CTRL_OKPOL_BIT  3
`define CTRL_SCENE_C_LO 4
`define CTRL_SCENE_D_LO 8
`define CTRL_SET_BIT    12

// Result register fields (write from the reading engine side)
`define RES_DONE_BIT    0
`define RES_GOOD_BIT    1

// Reset values
`define CTRL_RESET      32'h0000_0000
`define GATE_DELAY_RST  32'h0000_0000
`define GATE_ON_RST     32'h0000_0001
`define GATE_PERIOD_RST 32'h0000_0002
`define RETRY_RST       32'h0000_0000

// Minimum trigger width in ns, clock period in ns
`define TRIG_MIN_NS     500000
`define CLK_PERIOD_NS   4
`define TRIG_MIN_CYC    (`TRIG_MIN_NS / `CLK_PERIOD_NS)

`endif

//--- hdl/trig_filter.v
`timescale 1ns/10ps
`include "trig_defs.vh"

module trig_filter #(
	parameter N     = 4,
	parameter WIDTH = 125000
) (
	// Clock and reset
	input  wire         sys_clk,
	input  wire         rstn,
	// Raw and filtered triggers
	input  wire [N-1:0] trig_raw,
	output wire [N-1:0] trig_level,
	output wire [N-1:0] trig_rise
);

	genvar i;
	generate
		for (i = 0; i < N; i = i + 1) begin : g_ch
			reg        sync1_r;
			reg        sync2_r;
			reg        lvl_r;
			reg        lvl_d_r;
			reg [17:0] cnt_r;
			// Level only changes after the input stays put for WIDTH
			always @(posedge sys_clk or negedge rstn) begin
				if (!rstn) begin
					sync1_r <= 1'b0;
					sync2_r <= 1'b0;
					lvl_r   <= 1'b0;
					lvl_d_r <= 1'b0;
					cnt_r   <= 18'h00000;
				end else begin
					sync1_r <= trig_raw[i];
					sync2_r <= sync1_r;
					lvl_d_r <= lvl_r;
					if (sync2_r == lvl_r)
						cnt_r <= 18'h00000;
					else if (cnt_r >= WIDTH[17:0] - 18'h00001) begin
						lvl_r <= sync2_r;
						cnt_r <= 18'h00000;
					end else
						cnt_r <= cnt_r + 18'h00001;
				end
			end
			assign trig_level[i] = lvl_r;
			assign trig_rise[i]  = lvl_r & ~lvl_d_r;
		end
	endgenerate

endmodule // trig_filter

//--- hdl/gate_timer.v
`timescale 1ns/10ps
`include "trig_defs.vh"

module gate_timer #(
	parameter W = 32
) (
	// Clock and reset
	input  wire         sys_clk,
	input  wire         rstn,
	// Settings in cycles
	input  wire [W-1:0] delay_cyc,
	input  wire [W-1:0] on_cyc,
	input  wire [W-1:0] period_cyc,
	// Request and status
	input  wire         start,
	output wire         ready,
	output reg          gate
);

	localparam S_IDLE  = 4'b0001;
	localparam S_DELAY = 4'b0010;
	localparam S_ON    = 4'b0100;
	localparam S_REST  = 4'b1000;

	reg [3:0]   state_r;
	reg [W-1:0] cnt_r;
	reg [W-1:0] per_r;

	// Next strobe waits for the full period, so long periods lag
	assign ready = state_r == S_IDLE;

	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r <= S_IDLE;
			cnt_r   <= {W{1'b0}};
			per_r   <= {W{1'b0}};
			gate    <= 1'b0;
		end else begin
			if (state_r != S_IDLE)
				per_r <= per_r + 1'b1;
			case (state_r)
			S_IDLE: begin
				per_r <= {W{1'b0}};
				cnt_r <= {W{1'b0}};
				if (start) begin
					if (delay_cyc == {W{1'b0}}) begin
						state_r <= S_ON;
						gate    <= 1'b1;
					end else
						state_r <= S_DELAY;
				end
			end
			S_DELAY: begin
				if (cnt_r + 1'b1 >= delay_cyc) begin
					state_r <= S_ON;
					gate    <= 1'b1;
					cnt_r   <= {W{1'b0}};
				end else
					cnt_r <= cnt_r + 1'b1;
			end
			S_ON: begin
				if (cnt_r + 1'b1 >= on_cyc) begin
					state_r <= S_REST;
					gate    <= 1'b0;
				end else
					cnt_r <= cnt_r + 1'b1;
			end
			S_REST: begin
				if (per_r + 1'b1 >= period_cyc)
					state_r <= S_IDLE;
			end
			default: begin
				state_r <= S_IDLE;
				gate    <= 1'b0;
			end
			endcase
		end
	end

endmodule // gate_timer

//--- hdl/trigger_judgement_handshake.v
// Behaviour
// - Run indicator high exactly while the mode is run.
// - Busy high while reading or while applying a settings change.
// - Judgement output follows each result; polarity selects good or failed.
// - Strobe pulse marks when the host may sample the judgement.
// - Strobe delay, on-time and output period are configurable.
// - Strobe stays high for exactly the configured on-time; an on-time of 0 gives one cycle here.
// - Each rising one-shot trigger starts exactly one read.
// - Triggers are ignored while a read is in progress.
// - Continuous mode repeats reads while the continuous trigger is active.
// - Level mode repeats reads on B, C or D until good.
// - Level mode drives the outputs exactly as continuous mode does; here it strobes only on good or on release, not after each read.
// - Serial send time varies with data amount and baud rate.
// - Judgements are produced only in run mode, not in monitor mode.
// - Level mode outputs failed judgement when the trigger drops without good.
// - A failed one-shot read retries up to the retry count.
// - Scene C and D triggers switch scene first, then read; here C and D act only in level mode and are ignored otherwise.
//
// Added by the designer: the APB interface to the registers and the placing of the registers.
`timescale 1ns/10ps
`include "trig_defs.vh"

module trigger_judgement_handshake #(
	parameter TRIG_MIN_CYC = `TRIG_MIN_CYC
) (
	// Clock and reset
	input  wire        sys_clk,
	input  wire        rstn,
	// APB slave
	input  wire        psel,
	input  wire        penable,
	input  wire        pwrite,
	input  wire [11:0] paddr,
	input  wire [31:0] pwdata,
	output reg  [31:0] prdata,
	output wire        pready,
	output wire        pslverr,
	// Trigger pins
	input  wire        one_shot_trigger,
	input  wire        continuous_trigger,
	input  wire        scene_c_trigger,
	input  wire        scene_d_trigger,
	// Reading engine
	output reg         read_start,
	output reg  [3:0]  read_scene,
	input  wire        read_done,
	input  wire        read_good,
	input  wire        serial_busy,
	// Host outputs
	output wire        run_mode,
	output wire        busy,
	output reg         judgement_output,
	output wire        result_strobe
);

	localparam S_IDLE  = 4'b0001;
	localparam S_SCENE = 4'b0010;
	localparam S_READ  = 4'b0100;
	localparam S_POST  = 4'b1000;

	localparam SRC_A = 2'd0;
	localparam SRC_B = 2'd1;
	localparam SRC_C = 2'd2;
	localparam SRC_D = 2'd3;

	reg [31:0] ctrl_r;
	reg [31:0] gdelay_r;
	reg [31:0] gon_r;
	reg [31:0] gper_r;
	reg [31:0] retry_r;
	reg        set_busy_r;

	reg [3:0]  state_r;
	reg [1:0]  src_r;
	reg [31:0] tries_r;
	reg        have_result_r;
	reg        last_good_r;
	reg        pend_r;
	reg        pend_good_r;
	reg        gate_start_r;
	reg [31:0] reads_r;
	// Set after a good level read, cleared when its input drops
	reg        hold_r;

	wire [3:0] trig_lvl;
	wire [3:0] trig_rise;
	wire       gate_ready;
	wire       wr;
	wire       rd;
	wire       in_run;
	wire       in_mon;
	wire       level_mode;
	wire       src_lvl;
	wire       judge_pol;
	wire       go_c;
	wire       go_d;
	wire       go_b;

	assign wr         = psel & penable & pwrite;
	assign rd         = psel & ~pwrite;
	// Zero wait states: every access ends in its first access cycle
	assign pready     = 1'b1;
	assign pslverr    = 1'b0;
	assign in_run     = ctrl_r[`CTRL_RUN_BIT];
	// Run wins when both mode bits are set
	assign in_mon     = ctrl_r[`CTRL_MON_BIT] & ~in_run;
	assign level_mode = ctrl_r[`CTRL_LEVEL_BIT];
	assign judge_pol  = ctrl_r[`CTRL_OKPOL_BIT];
	assign src_lvl    = trig_lvl[src_r];
	// A level source that gave good stays quiet until it is released
	assign go_c       = trig_lvl[SRC_C] & level_mode & ~hold_r;
	assign go_d       = trig_lvl[SRC_D] & level_mode & ~hold_r;
	assign go_b       = trig_lvl[SRC_B] & ~(level_mode & hold_r);

	assign run_mode = in_run;
	// Serial send counts as processing, its length is outside this block
	assign busy = (state_r != S_IDLE) | set_busy_r | serial_busy;

	// Pins settle in the filter before any edge or level is seen
	trig_filter #(
		.N     (4),
		.WIDTH (TRIG_MIN_CYC)
	) u_filter (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.trig_raw   ({scene_d_trigger, scene_c_trigger,
		              continuous_trigger, one_shot_trigger}),
		.trig_level (trig_lvl),
		.trig_rise  (trig_rise)
	);

	// Strobe delay, width and spacing are counted in clock cycles
	gate_timer #(
		.W (32)
	) u_gate (
		.sys_clk    (sys_clk),
		.rstn       (rstn),
		.delay_cyc  (gdelay_r),
		.on_cyc     (gon_r),
		.period_cyc (gper_r),
		.start      (gate_start_r),
		.ready      (gate_ready),
		.gate       (result_strobe)
	);

	// Register writes; a settings write raises busy for one cycle
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r     <= `CTRL_RESET;
			gdelay_r   <= `GATE_DELAY_RST;
			gon_r      <= `GATE_ON_RST;
			gper_r     <= `GATE_PERIOD_RST;
			retry_r    <= `RETRY_RST;
			set_busy_r <= 1'b0;
		end else begin
			set_busy_r <= 1'b0;
			if (wr) begin
				set_busy_r <= 1'b1;
				case (paddr)
				`REG_CTRL:        ctrl_r   <= pwdata;
				`REG_GATE_DELAY:  gdelay_r <= pwdata;
				`REG_GATE_ON:     gon_r    <= pwdata;
				`REG_GATE_PERIOD: gper_r   <= pwdata;
				`REG_RETRY:       retry_r  <= pwdata;
				default:          set_busy_r <= 1'b0;
				endcase
			end
		end
	end

	// Read data is loaded in the setup cycle and holds through access
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn)
			prdata <= 32'h0000_0000;
		else if (rd) begin
			case (paddr)
			`REG_CTRL:        prdata <= ctrl_r;
			`REG_GATE_DELAY:  prdata <= gdelay_r;
			`REG_GATE_ON:     prdata <= gon_r;
			`REG_GATE_PERIOD: prdata <= gper_r;
			`REG_RETRY:       prdata <= retry_r;
			`REG_STATUS:      prdata <= {22'h000000, trig_lvl, state_r,
			                           busy, in_run};
			`REG_RESULT:      prdata <= reads_r;
			default:          prdata <= 32'h0000_0000;
			endcase
		end
	end

	// Read sequencer
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			state_r       <= S_IDLE;
			src_r         <= SRC_A;
			tries_r       <= 32'h0000_0000;
			read_start    <= 1'b0;
			read_scene    <= 4'h0;
			have_result_r <= 1'b0;
			last_good_r   <= 1'b0;
			pend_r        <= 1'b0;
			pend_good_r   <= 1'b0;
			reads_r       <= 32'h0000_0000;
			hold_r        <= 1'b0;
		end else begin
			read_start <= 1'b0;
			// In monitor no strobe is launched, so drop the result here
			if (pend_r && (gate_start_r || !in_run))
				pend_r <= 1'b0;
			// Hold ends once the source that gave good is released
			if (hold_r && !src_lvl)
				hold_r <= 1'b0;
			case (state_r)
			S_IDLE: begin
				// Retry budget starts afresh for each trigger
				tries_r <= 32'h0000_0000;
				if (!(in_run || in_mon) || ctrl_r[`CTRL_SET_BIT]) begin
					state_r <= S_IDLE;
				end else if (trig_rise[SRC_A]) begin
					src_r      <= SRC_A;
					state_r    <= S_READ;
					read_start <= 1'b1;
				end else if (go_c) begin
					src_r      <= SRC_C;
					read_scene <= ctrl_r[`CTRL_SCENE_C_LO+3:`CTRL_SCENE_C_LO];
					state_r    <= S_SCENE;
				end else if (go_d) begin
					src_r      <= SRC_D;
					read_scene <= ctrl_r[`CTRL_SCENE_D_LO+3:`CTRL_SCENE_D_LO];
					state_r    <= S_SCENE;
				end else if (go_b) begin
					src_r      <= SRC_B;
					state_r    <= S_READ;
					read_start <= 1'b1;
				end
			end
			S_SCENE: begin
				// Scene is switched one cycle ahead of the read
				state_r    <= S_READ;
				read_start <= 1'b1;
			end
			S_READ: begin
				// New triggers are not taken here; only a level-mode read checks its own source level
				if (read_done) begin
					reads_r <= reads_r + 32'h0000_0001;
					// A failed one-shot read is retried before judging
					if (src_r == SRC_A && !read_good &&
					    tries_r < retry_r) begin
						tries_r    <= tries_r + 32'h0000_0001;
						read_start <= 1'b1;
					end else if (src_r != SRC_A && level_mode) begin
						if (read_good) begin
							hold_r      <= 1'b1;
							pend_r      <= 1'b1;
							pend_good_r <= 1'b1;
							state_r     <= S_POST;
						end else if (!src_lvl) begin
							pend_r      <= 1'b1;
							pend_good_r <= 1'b0;
							state_r     <= S_POST;
						end else
							read_start <= 1'b1;
					end else begin
						pend_r      <= 1'b1;
						pend_good_r <= read_good;
						state_r     <= S_POST;
					end
				end
			end
			S_POST: begin
				// Stay until the judgement is queued to the strobe
				if (!pend_r) begin
					// Continuous mode goes on while its input stays active
					if (src_r == SRC_B && !level_mode && src_lvl) begin
						state_r    <= S_READ;
						read_start <= 1'b1;
					end else
						state_r <= S_IDLE;
				end
			end
			default: state_r <= S_IDLE;
			endcase
		end
	end

	// Judgement and strobe launch, only in run mode; a result seen in
	// monitor is dropped by the sequencer without touching the pins
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			judgement_output <= 1'b0;
			gate_start_r     <= 1'b0;
		end else begin
			gate_start_r <= 1'b0;
			if (pend_r && !gate_start_r && gate_ready &&
			    in_run) begin
				judgement_output <= pend_good_r ^ judge_pol;
				gate_start_r     <= 1'b1;
			end
		end
	end

endmodule // trigger_judgement_handshake

//--- verification/read_engine_model.sv
`timescale 1ns/10ps
module read_engine_model (
	// Clock and reset
	input  wire       sys_clk,
	input  wire       rstn,
	// Engine handshake
	input  wire       read_start,
	output reg        read_done,
	output reg        read_good,
	output wire       serial_busy,
	// Set by the bench
	input  wire       good_cfg,
	input  wire [7:0] lat
);
	reg [7:0] cnt_r;
	reg [3:0] ser_r;
	assign serial_busy = (ser_r != 4'h0);
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			cnt_r <= 8'h00;
			ser_r <= 4'h0;
			read_done <= 1'b0;
			read_good <= 1'b0;
		end else begin
			read_done <= 1'b0;
			// Result not valid: keep it moving
			read_good <= ~read_good;
			if (ser_r != 4'h0)
				ser_r <= ser_r - 4'h1;
			if (read_start) begin
				cnt_r <= lat;
			end else if (cnt_r == 8'h01) begin
				cnt_r <= 8'h00;
				read_done <= 1'b1;
				read_good <= good_cfg;
				ser_r <= 4'h4;
			end else if (cnt_r != 8'h00) begin
				cnt_r <= cnt_r - 8'h01;
			end
		end
	end
endmodule // read_engine_model

//--- verification/trigger_judgement_handshake_chk.sv
`timescale 1ns/10ps
`include "trig_defs.vh"
module trigger_judgement_handshake_chk #(
	parameter TRIG_MIN_CYC = 4
) (
	// Clock and reset
	input wire        sys_clk,
	input wire        rstn,
	// Bus writes
	input wire        psel,
	input wire        penable,
	input wire        pwrite,
	input wire [11:0] paddr,
	input wire [31:0] pwdata,
	// Engine and triggers
	input wire        read_start,
	input wire        read_done,
	input wire        read_good,
	input wire        continuous_trigger,
	// Host outputs
	input wire        run_mode,
	input wire        judgement_output,
	input wire        result_strobe
);
	reg  [31:0] ctrl_r;
	reg  [31:0] on_r;
	reg  [31:0] hi_r;
	reg         seen_r;
	reg         good_r;
	reg  [31:0] retry_r;
	wire        wr = psel & penable & pwrite;
	wire [31:0] on_exp = (on_r == 32'h0) ? 32'h1 : on_r;
	always @(posedge sys_clk or negedge rstn) begin
		if (!rstn) begin
			ctrl_r <= 32'h0;
			on_r <= 32'h1;
			hi_r <= 32'h0;
			seen_r <= 1'b0;
			good_r <= 1'b0;
			retry_r <= 32'h0;
		end else begin
			if (wr && paddr == `REG_CTRL)
				ctrl_r <= pwdata;
			if (wr && paddr == `REG_GATE_ON)
				on_r <= pwdata;
			if (wr && paddr == `REG_RETRY)
				retry_r <= pwdata;
			hi_r <= result_strobe ? hi_r + 32'h1 : 32'h0;
			if (read_done)
				seen_r <= 1'b1;
			if (read_done)
				good_r <= read_good;
		end
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (!rstn);
	property p_run;
		run_mode == ctrl_r[0];
	endproperty
	a_run: assert property (p_run) else $error("run flag wrong");
	property p_one;
		read_start |=> !read_start [*3];
	endproperty
	a_one: assert property (p_one) else $error("start repeated");
	property p_quiet;
		!seen_r |-> !judgement_output && !result_strobe;
	endproperty
	a_quiet: assert property (p_quiet) else $error("early output");
	property p_mon;
		ctrl_r[1] && !ctrl_r[0] |-> !$rose(result_strobe);
	endproperty
	a_mon: assert property (p_mon) else $error("strobe in monitor");
	property p_on;
		$fell(result_strobe) |-> hi_r == on_exp;
	endproperty
	a_on: assert property (p_on) else $error("strobe width wrong");
	property p_pol;
		read_done && (read_good || retry_r == 32'h0) &&
		ctrl_r[0] && !ctrl_r[2] |->
			##[1:4] judgement_output == (good_r ^ ctrl_r[3]);
	endproperty
	a_pol: assert property (p_pol) else $error("bad judgement");
	property p_cont;
		read_done && continuous_trigger && ctrl_r[0] && !ctrl_r[2] |->
			##[1:40] read_start;
	endproperty
	a_cont: assert property (p_cont) else $error("no repeat");
	property p_lvl;
		read_done && read_good && ctrl_r[2] |=> !read_start [*8];
	endproperty
	a_lvl: assert property (p_lvl) else $error("read after good");
endmodule // trigger_judgement_handshake_chk

bind trigger_judgement_handshake trigger_judgement_handshake_chk #(
	.TRIG_MIN_CYC(TRIG_MIN_CYC)
) chk (.*);

//--- verification/trigger_judgement_handshake_tb.sv
`timescale 1ns/10ps
`include "trig_defs.vh"
module trigger_judgement_handshake_tb;
	reg         sys_clk = 1'b0;
	reg         rstn = 1'b0;
	reg         psel = 1'b0;
	reg         penable = 1'b0;
	reg         pwrite = 1'b0;
	reg  [11:0] paddr = 12'h000;
	reg  [31:0] pwdata = 32'h0;
	reg  [3:0]  trg = 4'h0;
	reg         good_cfg = 1'b1;
	reg  [7:0]  lat = 8'h28;
	wire [31:0] prdata;
	wire        pready, pslverr, read_start, read_done, read_good;
	wire        serial_busy, run_mode, busy, judgement_output;
	wire        result_strobe;
	wire [3:0]  read_scene;
	wire        one_shot_trigger = trg[0];
	wire        continuous_trigger = trg[1];
	wire        scene_c_trigger = trg[2];
	wire        scene_d_trigger = trg[3];
	integer     n_mismatch = 0, comparisons = 0, n_starts = 0, n_strobe = 0;
	integer     s, k, g, p;
	reg  [31:0] rd;
	reg  [3:0]  scene_seen = 4'h0;
	trigger_judgement_handshake #(.TRIG_MIN_CYC(4)) dut (.*);
	read_engine_model eng (.*);
	always #2 sys_clk = ~sys_clk;
	always @(posedge sys_clk) begin
		if (read_start === 1'b1) begin
			n_starts <= n_starts + 1;
			scene_seen <= read_scene;
		end
		if (result_strobe === 1'b1 && $past(result_strobe) !== 1'b1)
			n_strobe <= n_strobe + 1;
	end
	task check(input [31:0] got, input [31:0] exp);
		begin
			comparisons = comparisons + 1;
			if (got !== exp) begin
				n_mismatch = n_mismatch + 1;
				$display("ERROR %0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task apb(input w, input [11:0] a, input [31:0] d);
		begin
			while (busy !== 1'b0)
				@(posedge sys_clk);
			psel <= 1'b1;
			pwrite <= w;
			paddr <= a;
			pwdata <= d;
			@(posedge sys_clk);
			penable <= 1'b1;
			@(posedge sys_clk);
			while (pready !== 1'b1)
				@(posedge sys_clk);
			rd = prdata;
			psel <= 1'b0;
			penable <= 1'b0;
			@(posedge sys_clk);
		end
	endtask
	task pulse(input [3:0] m);
		begin
			trg <= m;
			repeat (10) @(posedge sys_clk);
			trg <= 4'h0;
			@(posedge sys_clk);
		end
	endtask
	// Quiet for 20 cycles, so a delayed strobe is not missed
	task idle;
		integer q, t;
		begin
			q = 0;
			for (t = 0; t < 3000 && q < 20; t = t + 1) begin
				@(negedge sys_clk);
				q = (busy === 1'b0 && result_strobe === 1'b0) ? q + 1 : 0;
			end
			check(q, 20);
			@(posedge sys_clk);
		end
	endtask
	task t_reset;
		begin
			check({run_mode, busy, judgement_output, result_strobe}, 0);
			check({pready, pslverr}, 2'b10);
			apb(0, `REG_GATE_ON, 0);
			check(rd, `GATE_ON_RST);
			apb(0, `REG_GATE_PERIOD, 0);
			check(rd, `GATE_PERIOD_RST);
			apb(0, 12'h020, 0);
			check(rd, 32'h0);
		end
	endtask
	task t_oneshot;
		begin
			apb(1, `REG_GATE_DELAY, 32'h2);
			apb(1, `REG_GATE_ON, 32'h3);
			apb(1, `REG_GATE_PERIOD, 32'h8);
			for (p = 0; p < 2; p = p + 1)
				for (g = 0; g < 2; g = g + 1) begin
					apb(1, `REG_CTRL, 32'h1 | (p << 3));
					check(run_mode, 1);
					good_cfg <= g[0];
					s = n_starts;
					k = n_strobe;
					pulse(4'h1);
					check(busy, 1);
					pulse(4'h1);
					idle;
					check(n_starts - s, 1);
					check(n_strobe - k, 1);
					check(judgement_output, g ^ p);
				end
		end
	endtask
	task t_mon_retry;
		begin
			apb(1, `REG_CTRL, 32'h2);
			check(run_mode, 0);
			s = n_starts;
			k = n_strobe;
			pulse(4'h1);
			idle;
			check(n_starts - s, 1);
			check(n_strobe - k, 0);
			apb(1, `REG_CTRL, 32'h1);
			s = n_starts;
			trg <= 4'h1;
			repeat (2) @(posedge sys_clk);
			trg <= 4'h0;
			repeat (20) @(posedge sys_clk);
			check(n_starts, s);
			apb(1, `REG_RETRY, 32'h2);
			good_cfg <= 1'b0;
			s = n_starts;
			k = n_strobe;
			pulse(4'h1);
			idle;
			check(n_starts - s, 3);
			check(n_strobe - k, 1);
			apb(0, `REG_RESULT, 0);
			check(rd, 32'h8);
			apb(1, `REG_RETRY, 32'h0);
		end
	endtask
	task t_cont;
		begin
			good_cfg <= 1'b1;
			lat <= 8'h0A;
			s = n_starts;
			trg <= 4'h2;
			repeat (200) @(posedge sys_clk);
			check(n_starts - s > 3, 1);
			trg <= 4'h0;
			idle;
			s = n_starts;
			repeat (100) @(posedge sys_clk);
			check(n_starts, s);
		end
	endtask
	task t_level;
		begin
			apb(1, `REG_CTRL, 32'h0000_0955);
			good_cfg <= 1'b0;
			s = n_starts;
			k = n_strobe;
			trg <= 4'h4;
			repeat (150) @(posedge sys_clk);
			check(n_starts - s > 2, 1);
			check(scene_seen, 4'h5);
			check(n_strobe, k);
			good_cfg <= 1'b1;
			repeat (100) @(posedge sys_clk);
			s = n_starts;
			repeat (100) @(posedge sys_clk);
			check(n_starts, s);
			check(judgement_output, 1);
			trg <= 4'h0;
			idle;
			good_cfg <= 1'b0;
			k = n_strobe;
			trg <= 4'h8;
			repeat (100) @(posedge sys_clk);
			trg <= 4'h0;
			idle;
			check(scene_seen, 4'h9);
			check(n_strobe - k, 1);
			check(judgement_output, 0);
		end
	endtask
	task stop_test;
		begin
			$display("mismatches %0d comparisons %0d", n_mismatch, comparisons);
			if (n_mismatch == 0 && comparisons > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		repeat (30000) @(posedge sys_clk);
		n_mismatch = n_mismatch + 1;
		stop_test;
	end
	initial begin
		repeat (12) @(posedge sys_clk);
		rstn <= 1'b1;
		@(posedge sys_clk);
		t_reset;
		t_oneshot;
		t_mon_retry;
		t_cont;
		t_level;
		stop_test;
	end
endmodule // trigger_judgement_handshake_tb
